// ===== hw/serial_link_map.vh
// register offsets, field positions, reset values and timing counts of the single-bit serial link
`ifndef SERIAL_LINK_MAP_VH
`define SERIAL_LINK_MAP_VH

// register offsets on the plain register port
`define OFS_CONTROL_STATUS 3'h0
`define OFS_DATA           3'h1
`define OFS_CONFIG         3'h2
`define OFS_IRQ_ENABLE_ONE 3'h3
`define OFS_IRQ_ENABLE_TWO 3'h4
`define OFS_PRIORITY_LO    3'h5
`define OFS_PRIORITY_HI    3'h6
`define OFS_IRQ_STATUS     3'h7

// control/status read fields
`define RD_MASTER          4
`define RD_STOP_SEEN       3
`define RD_START_SEEN      2
`define RD_ARB_LOST        1
`define RD_DATA_READY      0
`define RD_ATTENTION       6
`define RD_RECEIVED        7
`define RD_TX_ACTIVE       5

// control/status write fields
`define WR_CLEAR_TX_ACTIVE 7
`define WR_IDLE            6
`define WR_CLEAR_DATA_READY_FLAG      5
`define WR_CLEAR_ARB       4
`define WR_CLEAR_START     3
`define WR_CLEAR_STOP      2
`define WR_SEND_START      1
`define WR_SEND_STOP       0

// config fields
`define CFG_SLAVE_EN       7
`define CFG_MASTER_REQ     6
`define CFG_TIMER_RUN      4
`define CFG_CT_HI          1
`define CFG_CT_LO          0

// interrupt enable bits
`define IEN_GLOBAL         7
`define IEN2_TIMEOUT       7
`define IEN2_LINK          0

// timing
`define MIN_SPAN_NS        4700
`define TIMER_WIDTH        10
`define SPAN_DONE          10'h008
// counts of 4 to 7 put the carry 1020 to 1023 ticks after a reload
`define CT_COUNT_0         4'h7
`define CT_COUNT_1         4'h6
`define CT_COUNT_2         4'h5
`define CT_COUNT_3         4'h4
`define MACHINE_DIV        6
`define RESET_CONFIG       8'h00
`endif

// ===== hw/serial_link_bit.v
// single-bit two-wire serial interface with timing and timeout timer
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "serial_link_map.vh"

// What this block does
// - timer counts machine cycles from CPU clock
// - low three timer bits time minimum spans
// - enforce high, start, stop, bus-free minimums
// - fast software still waits minimum SCL low
// - two-bit field selects one of four preloads
// - full ten timer bits time SCL stall
// - any SCL edge reloads timeout counter
// - timeout counter stopped between frames
// - carry after 1020 to 1023 cycles
// - carry resets interface, raises timeout interrupt
// - timeout reset releases SCL
// - timer runs past span count only with run bit set
// - timeout enable bit7, two priority bits
// - link interrupt enable at bit0
// - attention with enables requests interrupt
// - sample SDA on SCL rise
// - data read gives bit in MSB
// - data read clears ready; status read not
// - attention is OR of four flags
// - ready set on SCL rise unless idle
// - ready cleared by clear bit or data access
// - hold SCL low while ready pending
// - transmit bit driven only while SCL low
// - reload timer with eight minus count
// - drive SDA only transmitting or for a new master's start; flag loss only transmitting
// - master set on request with free bus
module serial_link_bit #(
	parameter MACHINE_DIV = `MACHINE_DIV
) (
	// clock and reset
	input  wire       REF_CLK,
	input  wire       NRST,
	// register port
	input  wire [2:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WR,
	input  wire       RD,
	output reg  [7:0] RDATA,
	// bus pins
	input  wire       SCL_IN,
	output reg        SCL_OUT,
	output reg        SCL_OE,
	input  wire       SDA_IN,
	output reg        SDA_OUT,
	output reg        SDA_OE,
	// interrupt requests and priorities
	output reg        LINK_IRQ,
	output reg        TIMEOUT_IRQ,
	output reg  [1:0] TIMEOUT_PRIORITY
);

	// preload count chosen by the clock-timing field
	function [3:0] span_count;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: span_count = `CT_COUNT_0;
				2'h1: span_count = `CT_COUNT_1;
				2'h2: span_count = `CT_COUNT_2;
				default: span_count = `CT_COUNT_3;
			endcase
		end
	endfunction

	reg       scl_meta, scl_sync, scl_last;
	reg       sda_meta, sda_sync, sda_last;
	reg [3:0] mc_div;
	reg       mc_tick;
	reg [9:0] timer;
	reg [7:0] serial_link_config_reg;
	reg [7:0] irq_enable_reg_one;
	reg [7:0] irq_enable_reg_two;
	reg [7:0] priority_lo;
	reg [7:0] priority_hi;
	reg       received_bit;
	reg       data_ready_flag;
	reg       arbitration_lost_flag;
	reg       start_seen_flag;
	reg       stop_seen_flag;
	reg       master;
	reg       tx_active;
	reg       transmit_bit;
	reg       idle_slave;
	reg       in_frame;
	reg       pending_stop;
	reg       pending_start;
	reg       req_dropped;
	reg       drive_sda_low;
	reg       drive_scl_low;
	reg       timeout_pending;

	wire attention_flag = data_ready_flag | arbitration_lost_flag | start_seen_flag | stop_seen_flag;
	wire scl_rise  = scl_sync & ~scl_last;
	wire scl_fall  = ~scl_sync & scl_last;
	wire scl_edge  = scl_rise | scl_fall;
	wire start_det = scl_sync & sda_last & ~sda_sync;
	wire stop_det  = scl_sync & ~sda_last & sda_sync;
	wire timer_run = serial_link_config_reg[`CFG_TIMER_RUN];
	wire enabled   = serial_link_config_reg[`CFG_SLAVE_EN] | serial_link_config_reg[`CFG_MASTER_REQ];
	wire span_done = (timer >= `SPAN_DONE);
	wire timeout   = timer_run & in_frame & mc_tick & (&timer);
	wire ctl_wr    = WR & (ADDR == `OFS_CONTROL_STATUS);
	wire dat_wr    = WR & (ADDR == `OFS_DATA);
	wire dat_rd    = RD & (ADDR == `OFS_DATA);
	wire [9:0] preload = {6'h00, 4'h8 - span_count({serial_link_config_reg[`CFG_CT_HI],
		serial_link_config_reg[`CFG_CT_LO]})};

	// two flip-flops on each pin before any logic looks at it
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			scl_last <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
			sda_last <= 1'b1;
		end else begin
			scl_meta <= SCL_IN;
			scl_sync <= scl_meta;
			scl_last <= scl_sync;
			sda_meta <= SDA_IN;
			sda_sync <= sda_meta;
			sda_last <= sda_sync;
		end
	end

	// machine cycle enable from the CPU clock
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			mc_div  <= 4'h0;
			mc_tick <= 1'b0;
		end else if (mc_div == MACHINE_DIV[3:0] - 4'h1) begin
			mc_div  <= 4'h0;
			mc_tick <= 1'b1;
		end else begin
			mc_div  <= mc_div + 4'h1;
			mc_tick <= 1'b0;
		end
	end

	// timer: preload on every SCL edge, saturate spans, wrap for timeout
	always @(posedge REF_CLK) begin
		if (!NRST || timeout) begin
			timer <= 10'h000;
		end else if (enabled && (scl_edge || start_det || stop_det)) begin
			// start and stop on the data wire reload too: they open the start hold and bus-free spans
			timer <= preload;
		end else if (mc_tick && (timer_run && in_frame || !span_done)) begin
			timer <= timer + 10'h001;
		end
	end

	// register writes; control strobes act the cycle they are written
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			serial_link_config_reg <= `RESET_CONFIG;
			irq_enable_reg_one     <= 8'h00;
			irq_enable_reg_two     <= 8'h00;
			priority_lo            <= 8'h00;
			priority_hi            <= 8'h00;
		end else if (WR) begin
			case (ADDR)
				`OFS_CONFIG:         serial_link_config_reg <= WDATA;
				`OFS_IRQ_ENABLE_ONE: irq_enable_reg_one <= WDATA;
				`OFS_IRQ_ENABLE_TWO: irq_enable_reg_two <= WDATA;
				`OFS_PRIORITY_LO:    priority_lo <= WDATA;
				`OFS_PRIORITY_HI:    priority_hi <= WDATA;
				default: ;
			endcase
		end
	end

	// bus protocol state: flags, master, transmit, frame tracking
	always @(posedge REF_CLK) begin
		if (!NRST || timeout) begin
			received_bit          <= 1'b0;
			data_ready_flag       <= 1'b0;
			arbitration_lost_flag <= 1'b0;
			start_seen_flag       <= 1'b0;
			stop_seen_flag        <= 1'b0;
			master                <= 1'b0;
			tx_active             <= 1'b0;
			transmit_bit          <= 1'b1;
			idle_slave            <= 1'b1;
			in_frame              <= 1'b0;
			pending_stop          <= 1'b0;
			pending_start         <= 1'b0;
			req_dropped           <= 1'b0;
			drive_sda_low         <= 1'b0;
			drive_scl_low         <= 1'b0;
		end else begin
			// software side first; hardware events below win over clears
			if (ctl_wr) begin
				if (WDATA[`WR_CLEAR_DATA_READY_FLAG])
					data_ready_flag <= 1'b0;
				if (WDATA[`WR_CLEAR_ARB])
					arbitration_lost_flag <= 1'b0;
				if (WDATA[`WR_CLEAR_START])
					start_seen_flag <= 1'b0;
				if (WDATA[`WR_CLEAR_STOP])
					stop_seen_flag <= 1'b0;
				if (WDATA[`WR_CLEAR_TX_ACTIVE])
					tx_active <= 1'b0;
				if (WDATA[`WR_IDLE])
					idle_slave <= 1'b1;
				if (WDATA[`WR_SEND_START]) begin
					tx_active     <= 1'b1;
					transmit_bit  <= 1'b1;
					pending_start <= 1'b1;
				end
				if (WDATA[`WR_SEND_STOP]) begin
					tx_active    <= 1'b1;
					transmit_bit <= 1'b0;
					pending_stop <= 1'b1;
					if (req_dropped)
						master <= 1'b0;
				end
			end
			if (dat_wr) begin
				transmit_bit    <= WDATA[7];
				tx_active       <= 1'b1;
				data_ready_flag <= 1'b0;
			end
			if (dat_rd) begin
				data_ready_flag <= 1'b0;
				tx_active       <= 1'b0;
			end
			// inverted request bit of the last cycle, for the drop-then-stop rule
			if (!serial_link_config_reg[`CFG_MASTER_REQ])
				req_dropped <= 1'b1;
			else
				req_dropped <= 1'b0;
			// become master when requested on a free bus after bus-free time
			if (serial_link_config_reg[`CFG_MASTER_REQ] && !in_frame && !master && span_done) begin
				master        <= 1'b1;
				drive_sda_low <= 1'b1;
			end
			// SCL rising: sample, ready, arbitration
			if (scl_rise) begin
				received_bit <= sda_sync;
				if (!idle_slave || master)
					data_ready_flag <= 1'b1;
				if (tx_active && transmit_bit && !sda_sync) begin
					arbitration_lost_flag <= 1'b1;
					tx_active             <= 1'b0;
					master                <= 1'b0;
				end
			end
			// start condition
			if (start_det) begin
				in_frame <= 1'b1;
				if (!idle_slave || master)
					start_seen_flag <= 1'b1;
				idle_slave <= 1'b0;
			end
			// stop condition
			if (stop_det) begin
				in_frame <= 1'b0;
				if (!idle_slave || master)
					stop_seen_flag <= 1'b1;
				drive_sda_low <= 1'b0;
				pending_stop  <= 1'b0;
			end
			// drive SDA only during SCL low, then held through the high phase
			if (!scl_sync && !drive_scl_low)
				drive_sda_low <= tx_active & ~transmit_bit;
			// stop: release SDA after minimum SCL high to SDA high
			if (pending_stop && scl_sync && span_done)
				drive_sda_low <= 1'b0;
			// repeated start: pull SDA low after minimum time
			if (pending_start && scl_sync && span_done) begin
				drive_sda_low <= 1'b1;
				pending_start <= 1'b0;
			end
			// master clocking: high minimum, low minimum and stretching
			// a new master waits until its own start is seen, so the reloaded timer
			// keeps SCL high for the minimum SDA low to SCL low span
			if (master && in_frame && scl_sync && span_done && !pending_stop)
				drive_scl_low <= ~pending_start;
			if (scl_fall && !master)
				drive_scl_low <= 1'b1;
			if (drive_scl_low && !attention_flag && span_done && (master || !scl_sync))
				drive_scl_low <= 1'b0;
			if (!scl_sync && attention_flag)
				drive_scl_low <= 1'b1;
		end
	end

	// outputs straight from flip-flops
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			SCL_OUT          <= 1'b0;
			SCL_OE           <= 1'b0;
			SDA_OUT          <= 1'b0;
			SDA_OE           <= 1'b0;
			LINK_IRQ         <= 1'b0;
			TIMEOUT_IRQ      <= 1'b0;
			TIMEOUT_PRIORITY <= 2'h0;
			timeout_pending  <= 1'b0;
		end else begin
			// open drain: only the enables move, the data outputs stay low
			SCL_OUT          <= 1'b0;
			SCL_OE           <= drive_scl_low & ~timeout;
			SDA_OUT          <= 1'b0;
			SDA_OE           <= drive_sda_low & ~timeout;
			LINK_IRQ         <= irq_enable_reg_one[`IEN_GLOBAL] & irq_enable_reg_two[`IEN2_LINK] &
				attention_flag;
			// timeout request held until the enable is dropped
			if (timeout)
				timeout_pending <= 1'b1;
			else if (!irq_enable_reg_two[`IEN2_TIMEOUT])
				timeout_pending <= 1'b0;
			TIMEOUT_IRQ      <= irq_enable_reg_one[`IEN_GLOBAL] & irq_enable_reg_two[`IEN2_TIMEOUT] &
				(timeout_pending | timeout);
			TIMEOUT_PRIORITY <= {priority_hi[`IEN2_TIMEOUT], priority_lo[`IEN2_TIMEOUT]};
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always @(posedge REF_CLK) begin
		if (!NRST || !RD) begin
			RDATA <= 8'h00;
		end else begin
			case (ADDR)
				`OFS_CONTROL_STATUS: RDATA <= {received_bit, attention_flag, tx_active, master,
					stop_seen_flag, start_seen_flag, arbitration_lost_flag, data_ready_flag};
				`OFS_DATA:           RDATA <= {received_bit, 7'h00};
				`OFS_CONFIG:         RDATA <= serial_link_config_reg;
				`OFS_IRQ_ENABLE_ONE: RDATA <= irq_enable_reg_one;
				`OFS_IRQ_ENABLE_TWO: RDATA <= irq_enable_reg_two;
				`OFS_PRIORITY_LO:    RDATA <= priority_lo;
				`OFS_PRIORITY_HI:    RDATA <= priority_hi;
				default:             RDATA <= {7'h00, timeout_pending};
			endcase
		end
	end

endmodule

// ===== tb/serial_link_bit_asserts.sv
// concurrent checks on the serial link ports
`timescale 1ns/1ps
module serial_link_bit_asserts #(
	parameter MACHINE_DIV = 6
) (
	// clock and reset
	input wire       REF_CLK,
	input wire       NRST,
	// register port
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire       WR,
	input wire       RD,
	input wire [7:0] RDATA,
	// pins and requests
	input wire       SCL_IN,
	input wire       SCL_OE,
	input wire       TIMEOUT_IRQ,
	input wire [1:0] TIMEOUT_PRIORITY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	reg [15:0] quiet;
	reg        scl_d;
	// cycles since the clock pin last moved, saturating
	always @(posedge REF_CLK) begin
		scl_d <= SCL_IN;
		if (!NRST || SCL_IN != scl_d)
			quiet <= 16'h0000;
		else if (quiet != 16'hffff)
			quiet <= quiet + 16'h0001;
	end
	property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
	property p_dat; RD && ADDR == 3'h1 |=> RDATA[6:0] == 7'h00; endproperty
	a_dat: assert property (p_dat) else $error("data low bits not zero");
	property p_atn; RD && ADDR == 3'h0 |=> RDATA[6] == (|RDATA[3:0]); endproperty
	a_atn: assert property (p_atn) else $error("attention not flag or");
	property p_plo; WR && ADDR == 3'h5 && WDATA[7] |-> ##[1:2] TIMEOUT_PRIORITY[0]; endproperty
	a_plo: assert property (p_plo) else $error("low priority bit lost");
	property p_phi; WR && ADDR == 3'h6 && !WDATA[7] |-> ##[1:2] !TIMEOUT_PRIORITY[1]; endproperty
	a_phi: assert property (p_phi) else $error("high priority bit stuck");
	property p_rel; $rose(TIMEOUT_IRQ) |-> ##[0:2] !SCL_OE; endproperty
	a_rel: assert property (p_rel) else $error("clock held after timeout");
	// phase of the machine tick costs up to one machine cycle
	property p_span; $rose(TIMEOUT_IRQ) |-> quiet >= 1019 * MACHINE_DIV && quiet <= 1024 * MACHINE_DIV + 8; endproperty
	a_span: assert property (p_span) else $error("timeout span off");
	property p_still; $rose(TIMEOUT_IRQ) |-> $past(SCL_IN, 8) == SCL_IN; endproperty
	a_still: assert property (p_still) else $error("timeout after clock edge");
endmodule
bind serial_link_bit serial_link_bit_asserts #(.MACHINE_DIV(MACHINE_DIV)) chk_i (.REF_CLK(REF_CLK), .NRST(NRST),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OE(SCL_OE),
	.TIMEOUT_IRQ(TIMEOUT_IRQ), .TIMEOUT_PRIORITY(TIMEOUT_PRIORITY));

// ===== tb/bus_peer.sv
// far-side master model, open drain on both wires
`timescale 1ns/1ps
module bus_peer #(
	parameter HALF = 40
) (
	// clock and clock wire level
	input wire  clk,
	input wire  scl,
	// pull-downs; a released wire floats high
	output reg  scl_pull,
	output reg  sda_pull
);
	integer i;
	// both wires released from time zero
	initial begin
		scl_pull <= 1'b0;
		sda_pull <= 1'b0;
	end
	task idle(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// data changes only while clock is low; waits out stretching
	task rise(input b);
		sda_pull <= !b;
		idle(HALF);
		scl_pull <= 1'b0;
		for (i = 0; i < 4000 && scl !== 1'b1; i = i + 1)
			@(posedge clk);
		idle(HALF);
	endtask
	task fall;
		scl_pull <= 1'b1;
		idle(HALF);
	endtask
	// data falls while clock is high
	task start;
		sda_pull <= 1'b1;
		idle(HALF);
		fall;
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the single-bit serial link
`timescale 1ns/1ps
`include "serial_link_map.vh"
module testbench;
	reg         clk = 1'b0;
	reg         nrst;
	reg  [2:0]  addr;
	reg  [7:0]  wdata;
	reg         wr;
	reg         rd;
	wire [7:0]  rdata;
	wire        scl_oe, sda_oe, scl_pull, sda_pull, link_irq, tmo_irq, scl_out, sda_out;
	wire [1:0]  prio;
	wire        scl = !(scl_oe | scl_pull);
	wire        sda = !(sda_oe | sda_pull);
	integer     error_cnt = 0;
	integer     n_tests = 0;
	integer     seed = 41;
	integer     k;
	reg  [31:0] r;
	reg  [7:0]  q;
	reg         b;
	always #5 clk = !clk;
	serial_link_bit #(.MACHINE_DIV(2)) dut (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .LINK_IRQ(link_irq), .TIMEOUT_IRQ(tmo_irq), .TIMEOUT_PRIORITY(prio));
	bus_peer peer (.clk(clk), .scl(scl), .scl_pull(scl_pull), .sda_pull(sda_pull));
	// expected flag bits with only data-ready possibly set
	function [7:0] fl(input d);
		fl = {1'b0, d, 5'h00, d};
	endfunction
	task chk(input [8*6:1] name, input [7:0] got, input [7:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch %0s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr_reg(input [2:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe
	task rd_reg(input [2:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		error_cnt = error_cnt + 1;
		conclude;
	end
	initial begin
		nrst  <= 1'b0;
		addr  <= 3'h0;
		wdata <= 8'h00;
		wr    <= 1'b0;
		rd    <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (k = 2; k < 8; k = k + 1) begin
			rd_reg(k[2:0]);
			chk("reset", q, 8'h00);
		end
		// random priority bits
		for (k = 0; k < 4; k = k + 1) begin
			r = $random(seed);
			wr_reg(`OFS_PRIORITY_LO, r[7:0]);
			wr_reg(`OFS_PRIORITY_HI, r[15:8]);
			// the priority output follows the register one cycle later
			@(posedge clk);
			@(negedge clk);
			chk("prio", {6'h00, prio}, {6'h00, r[15], r[7]});
		end
		// an idle slave ignores clock edges outside a frame
		wr_reg(`OFS_CONFIG, 8'h80);
		wr_reg(`OFS_CONTROL_STATUS, 8'h40);
		peer.fall;
		peer.rise(1'b1);
		rd_reg(`OFS_CONTROL_STATUS);
		chk("idle", q & 8'h4f, fl(1'b0));
		wr_reg(`OFS_IRQ_ENABLE_ONE, 8'h80);
		wr_reg(`OFS_IRQ_ENABLE_TWO, 8'h81);
		// stuck clock with the timer stopped does nothing
		peer.start;
		peer.idle(2300);
		chk("stop", {7'h00, tmo_irq}, 8'h00);
		wr_reg(`OFS_CONTROL_STATUS, 8'h3c);
		// bits under every timing selection, longer than one timeout
		for (k = 0; k < 16; k = k + 1) begin
			wr_reg(`OFS_CONFIG, {6'h24, k[1:0]});
			r = $random(seed);
			b = r[0];
			peer.rise(b);
			peer.fall;
			chk("hold", {7'h00, scl_oe}, 8'h01);
			rd_reg(`OFS_CONTROL_STATUS);
			chk("flags", q & 8'h4f, fl(1'b1));
			chk("rx", {7'h00, q[7]}, {7'h00, b});
			chk("irq", {7'h00, link_irq}, 8'h01);
			chk("hold2", {7'h00, scl_oe}, 8'h01);
			if (k == 5) begin
				wr_reg(`OFS_IRQ_ENABLE_TWO, 8'h80);
				@(posedge clk);
				@(negedge clk);
				chk("irqen", {7'h00, link_irq}, 8'h00);
				wr_reg(`OFS_IRQ_ENABLE_TWO, 8'h81);
			end
			if (k[0])
				wr_reg(`OFS_CONTROL_STATUS, 8'h20);
			else begin
				rd_reg(`OFS_DATA);
				chk("data", q, {b, 7'h00});
			end
			rd_reg(`OFS_CONTROL_STATUS);
			chk("clr", q & 8'h4f, fl(1'b0));
		end
		chk("run", {7'h00, tmo_irq}, 8'h00);
		// transmit written while the clock is still high
		peer.rise(1'b1);
		wr_reg(`OFS_DATA, 8'h00);
		peer.idle(4);
		chk("early", {7'h00, sda_oe}, 8'h00);
		peer.fall;
		chk("drive", {7'h00, sda_oe}, 8'h01);
		peer.rise(1'b1);
		peer.fall;
		rd_reg(`OFS_DATA);
		chk("wired", q, 8'h00);
		peer.idle(4);
		chk("free", {7'h00, sda_oe}, 8'h00);
		// no answer: the timeout frees the clock
		peer.rise(1'b1);
		peer.fall;
		for (k = 0; k < 2300 && tmo_irq !== 1'b1; k = k + 1)
			@(posedge clk);
		peer.idle(4);
		chk("tmo", {7'h00, tmo_irq}, 8'h01);
		chk("rel", {7'h00, scl_oe}, 8'h00);
		rd_reg(`OFS_IRQ_STATUS);
		chk("pend", q & 8'h01, 8'h01);
		// between frames the stuck clock never times out again
		wr_reg(`OFS_IRQ_ENABLE_TWO, 8'h01);
		wr_reg(`OFS_IRQ_ENABLE_TWO, 8'h81);
		rd_reg(`OFS_IRQ_STATUS);
		chk("unpend", q & 8'h01, 8'h00);
		peer.idle(2300);
		chk("nofr", {7'h00, tmo_irq}, 8'h00);
		// bus released, then a master request on the free bus sends a start
		peer.rise(1'b1);
		wr_reg(`OFS_CONFIG, 8'hd0);
		for (k = 0; k < 200 && sda_oe !== 1'b1; k = k + 1)
			@(negedge clk);
		for (k = 0; k < 200 && scl_oe !== 1'b1; k = k + 1)
			@(negedge clk);
		chk("sthold", {7'h00, k >= 2 * `CT_COUNT_0}, 8'h01);
		peer.idle(4);
		rd_reg(`OFS_CONTROL_STATUS);
		chk("master", q & 8'h5f, 8'h54);
		chk("mscl", {6'h00, scl_oe, sda_oe}, 8'h03);
		chk("odrain", {6'h00, scl_out, sda_out}, 8'h00);
		conclude;
	end
endmodule
